// >>> hdl/tcc_pkg.sv
/*
 package for the timer channel count/compare core: register indices,
 reset values, field positions, modes and carrier structs.
 assumes one clock domain and the internal 16-bit register bus.
*/
package tcc_pkg;
    // ==========================================================
    // register word indices
    localparam logic [4:0] ADR_STRIDE = 5'h03;
    localparam logic [4:0] ADR_CNT = 5'h00;
    localparam logic [4:0] ADR_GRA = 5'h01;
    localparam logic [4:0] ADR_GRB = 5'h02;
    localparam logic [4:0] ADR_OCR = 5'h0F;
    localparam logic [4:0] ADR_OER = 5'h10;
    // ==========================================================
    // reset values and fields
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [15:0] RST_GR = 16'hFFFF;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    localparam logic [7:0] RST_OCR = 8'hFF;
    localparam logic [7:0] RST_OER = 8'hFF;
    localparam logic [7:0] OCR_RSV = 8'hEC;
    localparam logic [7:0] OER_RSV = 8'hC0;
    localparam logic [7:0] OER_TRIP = 8'h3F;
    localparam int OCR_EXT_TRIGGER_DISABLE = 4;
    localparam int OCR_LVL_HI = 1;
    localparam int OCR_LVL_LO = 0;
    // ==========================================================
    // modes
    typedef enum logic [1:0] {
        IO_CMP = 2'h0, IO_RISE = 2'h1, IO_FALL = 2'h2, IO_BOTH = 2'h3
    } tcc_io_t;
    typedef enum logic [1:0] {
        CLR_NONE = 2'h0, CLR_A = 2'h1, CLR_B = 2'h2
    } tcc_clr_t;
    typedef enum logic [1:0] {
        PAIR_NONE = 2'h0, PAIR_COMP = 2'h1, PAIR_RSYNC = 2'h3
    } tcc_pair_t;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } tcc_cpu_req_t;
    typedef struct packed {
        logic [2:0] prescale_select;
        tcc_clr_t clr;
        tcc_io_t io_a;
        tcc_io_t io_b;
        logic pwm;
        logic down;
    } tcc_chan_cfg_t;
    typedef struct packed {
        logic [4:0][15:0] cnt;
        logic [4:0][15:0] general_reg_a;
        logic [4:0][15:0] general_reg_b;
        logic [4:0] f_wrap;
        logic [4:0] f_a;
        logic [4:0] f_b;
        logic [7:0] ocr;
        logic [7:0] oer;
        logic [9:0] cap_s1;
        logic [9:0] cap_s2;
        logic [9:0] cap_s3;
        logic [15:0] rdata;
        logic [5:0] pin_lvl;
        logic [5:0] pin_oe_n;
    } tcc_state_t;
endpackage : tcc_pkg

// >>> hdl/tcc_core.sv
/*
 five-channel 16-bit count/compare/capture core with output control.
 assumes prescaler ticks and raw pwm levels come from logic on clk;
 capture pins are asynchronous and synchronised here.
*/
`timescale 1ns/10ps
// What this block does
// R1: output control reserved bits read one
// R2: output control all ones on reset/standby
// R3: trigger and level bits only in pairs
// R4: channel 1 capture A is trigger
// R5: trigger clears master enable bits 5-0
// R6: trigger disable set blocks enable clearing
// R7: level hi bit inverts ch3a ch4a ch4b
// R8: level lo bit inverts ch3b and aux
// R9: five 16-bit counters, ch0/ch1 up only
// R10: channel 2 down only in phase counting
// R11: channels 3/4 down only complementary pwm
// R12: count on prescale selected tick
// R13: own-channel match or capture clears counter
// R14: up wrap sets wrap flag
// R15: down wrap sets wrap flag
// R16: word or byte cpu access
// R17: counters zero on reset/standby
// R18: two general registers per channel
// R19: compare equality sets match flag
// R20: capture edge latches count, sets flag
// R21: io control ignored in pwm modes
// R22: general registers compare, all ones initially
// R23: master enable gates ch3/ch4 pins
// R24: buffer pairing handled outside this core
// R25: cpu count write beats count tick
module tcc_core (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic standby,
    input wire tcc_pkg::tcc_cpu_req_t cpu,
    output logic [15:0] cpu_rdata,
    input wire tcc_pkg::tcc_chan_cfg_t [4:0] chan_cfg,
    input wire logic phase_mode,
    input wire tcc_pkg::tcc_pair_t pair_mode,
    input wire logic [7:0] src_tick,
    input wire logic [9:0] cap_pin,
    input wire logic [4:0] wrap_clr,
    input wire logic [4:0] flag_a_clr,
    input wire logic [4:0] flag_b_clr,
    input wire logic [5:0] raw_lvl,
    input wire logic [5:0] raw_en,
    output logic [4:0] count_wrap_flag,
    output logic [4:0] match_capture_flag_a,
    output logic [4:0] match_capture_flag_b,
    output logic [7:0] output_master_enable,
    output logic [5:0] pin_lvl,
    output logic [5:0] pin_oe_n
);
    // ==========================================================
    // helpers
    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [15:0] wd, input logic [1:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge

    function automatic logic [4:0] adr(input int ch, input logic [4:0] k);
        adr = 5'(ch * 3) + k;
    endfunction : adr

    function automatic logic edge_hit(input tcc_pkg::tcc_io_t io,
        input logic prev, input logic cur);
        case (io)
            tcc_pkg::IO_RISE: edge_hit = cur & ~prev;
            tcc_pkg::IO_FALL: edge_hit = prev & ~cur;
            tcc_pkg::IO_BOTH: edge_hit = cur ^ prev;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // ==========================================================
    // state
    tcc_pkg::tcc_state_t st_ff;
    tcc_pkg::tcc_state_t nxt_st;
    logic [4:0] hit_a, hit_b, cap_a, cap_b, tick, dn, cnt_wr, clr_hit;
    logic pair_on, trip, oer_wr, inv_hi, inv_lo;
    tcc_pkg::tcc_io_t io_a, io_b;
    logic ign;

    always_comb begin
        nxt_st = st_ff;
        hit_a = '0;
        hit_b = '0;
        cap_a = '0;
        cap_b = '0;
        tick = '0;
        dn = '0;
        cnt_wr = '0;
        clr_hit = '0;
        io_a = tcc_pkg::IO_CMP;
        io_b = tcc_pkg::IO_CMP;
        ign = 1'b0;
        // R3: pair-mode gating of trigger and levels
        pair_on = pair_mode != tcc_pkg::PAIR_NONE;
        // pin samples: stage 1 feeds stage 2 only
        nxt_st.cap_s1 = cap_pin;
        nxt_st.cap_s2 = st_ff.cap_s1;
        nxt_st.cap_s3 = st_ff.cap_s2;
        trip = 1'b0;
        for (int ch = 0; ch < 5; ch++) begin
            // R21: io control ignored in pwm modes
            ign = chan_cfg[ch].pwm | (ch >= 3 && pair_on);
            io_a = ign ? tcc_pkg::IO_CMP : chan_cfg[ch].io_a;
            io_b = ign ? tcc_pkg::IO_CMP : chan_cfg[ch].io_b;
            // R18: two general registers each channel
            // R19: compare equality
            // R20: capture on chosen edge
            if (io_a == tcc_pkg::IO_CMP) begin
                hit_a[ch] = st_ff.cnt[ch] == st_ff.general_reg_a[ch];
            end else begin
                cap_a[ch] = edge_hit(io_a, st_ff.cap_s3[2*ch],
                    st_ff.cap_s2[2*ch]);
                hit_a[ch] = cap_a[ch];
            end
            if (io_b == tcc_pkg::IO_CMP) begin
                hit_b[ch] = st_ff.cnt[ch] == st_ff.general_reg_b[ch];
            end else begin
                cap_b[ch] = edge_hit(io_b, st_ff.cap_s3[2*ch+1],
                    st_ff.cap_s2[2*ch+1]);
                hit_b[ch] = cap_b[ch];
            end
            // capture wins over a cpu write in the same cycle
            if (cap_a[ch]) begin
                nxt_st.general_reg_a[ch] = st_ff.cnt[ch];
            end else if (cpu.wr &&
                cpu.addr == adr(ch, tcc_pkg::ADR_GRA)) begin
                // R16: byte or word write
                nxt_st.general_reg_a[ch] = merge(st_ff.general_reg_a[ch], cpu.wdata, cpu.be);
            end
            if (cap_b[ch]) begin
                nxt_st.general_reg_b[ch] = st_ff.cnt[ch];
            end else if (cpu.wr &&
                cpu.addr == adr(ch, tcc_pkg::ADR_GRB)) begin
                nxt_st.general_reg_b[ch] = merge(st_ff.general_reg_b[ch], cpu.wdata, cpu.be);
            end
            // set wins over clear for every flag
            nxt_st.f_a[ch] = (st_ff.f_a[ch] & ~flag_a_clr[ch]) | hit_a[ch];
            nxt_st.f_b[ch] = (st_ff.f_b[ch] & ~flag_b_clr[ch]) | hit_b[ch];
            // R13: counter clearing source
            clr_hit[ch] = (chan_cfg[ch].clr == tcc_pkg::CLR_A && hit_a[ch])
                || (chan_cfg[ch].clr == tcc_pkg::CLR_B && hit_b[ch]);
            // R12: prescale selected tick
            tick[ch] = src_tick[chan_cfg[ch].prescale_select];
            // R9: R10: R11: direction allowed per channel
            dn[ch] = chan_cfg[ch].down &
                ((ch == 2 && phase_mode) ||
                 (ch >= 3 && pair_mode == tcc_pkg::PAIR_COMP));
            cnt_wr[ch] = cpu.wr && cpu.addr == adr(ch, tcc_pkg::ADR_CNT);
            nxt_st.f_wrap[ch] = st_ff.f_wrap[ch] & ~wrap_clr[ch];
            // R25: cpu write discards the tick
            if (cnt_wr[ch]) begin
                nxt_st.cnt[ch] = merge(st_ff.cnt[ch], cpu.wdata, cpu.be);
            end else if (clr_hit[ch]) begin
                nxt_st.cnt[ch] = tcc_pkg::RST_CNT;
            end else if (tick[ch]) begin
                if (dn[ch]) begin
                    nxt_st.cnt[ch] = st_ff.cnt[ch] - 16'h0001;
                    // R15: down wrap
                    if (st_ff.cnt[ch] == tcc_pkg::RST_CNT) begin
                        nxt_st.f_wrap[ch] = 1'b1;
                    end
                end else begin
                    nxt_st.cnt[ch] = st_ff.cnt[ch] + 16'h0001;
                    // R14: up wrap
                    if (st_ff.cnt[ch] == tcc_pkg::CNT_TOP) begin
                        nxt_st.f_wrap[ch] = 1'b1;
                    end
                end
            end
        end
        // R4: channel 1 capture A as trigger
        // R6: disable bit blocks it
        trip = cap_a[1] & pair_on & ~st_ff.ocr[tcc_pkg::OCR_EXT_TRIGGER_DISABLE];
        // R1: reserved bits forced to one
        if (cpu.wr && cpu.addr == tcc_pkg::ADR_OCR && cpu.be[0]) begin
            nxt_st.ocr = cpu.wdata[7:0] | tcc_pkg::OCR_RSV;
        end
        oer_wr = cpu.wr && cpu.addr == tcc_pkg::ADR_OER && cpu.be[0];
        if (oer_wr) begin
            nxt_st.oer = cpu.wdata[7:0] | tcc_pkg::OER_RSV;
        end
        // R5: trigger beats a cpu write
        if (trip) begin
            nxt_st.oer = nxt_st.oer & ~tcc_pkg::OER_TRIP;
        end
        // R7: R8: level inversion in pair modes
        inv_hi = pair_on & ~st_ff.ocr[tcc_pkg::OCR_LVL_HI];
        inv_lo = pair_on & ~st_ff.ocr[tcc_pkg::OCR_LVL_LO];
        nxt_st.pin_lvl = raw_lvl ^ {inv_lo, inv_lo, inv_hi, inv_hi,
            inv_lo, inv_hi};
        // R23: pins 0..5 = ch3a ch3b ch4a ch4b auxa auxb
        nxt_st.pin_oe_n = ~(raw_en & {st_ff.oer[5], st_ff.oer[4],
            st_ff.oer[2], st_ff.oer[1], st_ff.oer[3], st_ff.oer[0]});
        // registered read; unmapped reads zero
        if (cpu.rd) begin
            nxt_st.rdata = 16'h0000;
            for (int ch = 0; ch < 5; ch++) begin
                if (cpu.addr == adr(ch, tcc_pkg::ADR_CNT)) begin
                    nxt_st.rdata = st_ff.cnt[ch];
                end
                if (cpu.addr == adr(ch, tcc_pkg::ADR_GRA)) begin
                    nxt_st.rdata = st_ff.general_reg_a[ch];
                end
                if (cpu.addr == adr(ch, tcc_pkg::ADR_GRB)) begin
                    nxt_st.rdata = st_ff.general_reg_b[ch];
                end
            end
            if (cpu.addr == tcc_pkg::ADR_OCR) begin
                nxt_st.rdata = {8'h00, st_ff.ocr};
            end
            if (cpu.addr == tcc_pkg::ADR_OER) begin
                nxt_st.rdata = {8'h00, st_ff.oer};
            end
        end
        // R2: R17: R22: standby initialises registers
        if (standby) begin
            nxt_st.cnt = {5{tcc_pkg::RST_CNT}};
            nxt_st.general_reg_a = {5{tcc_pkg::RST_GR}};
            nxt_st.general_reg_b = {5{tcc_pkg::RST_GR}};
            nxt_st.ocr = tcc_pkg::RST_OCR;
            nxt_st.oer = tcc_pkg::RST_OER;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= '0;
            st_ff.general_reg_a <= {5{tcc_pkg::RST_GR}};
            st_ff.general_reg_b <= {5{tcc_pkg::RST_GR}};
            st_ff.ocr <= tcc_pkg::RST_OCR;
            st_ff.oer <= tcc_pkg::RST_OER;
            st_ff.pin_oe_n <= 6'h3F;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cpu_rdata = st_ff.rdata;
    assign count_wrap_flag = st_ff.f_wrap;
    assign match_capture_flag_a = st_ff.f_a;
    assign match_capture_flag_b = st_ff.f_b;
    assign output_master_enable = st_ff.oer;
    assign pin_lvl = st_ff.pin_lvl;
    assign pin_oe_n = st_ff.pin_oe_n;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_up_wrap;
        st_ff.cnt[0] == 16'hFFFF && tick[0] && !cnt_wr[0] && !clr_hit[0]
            && !standby;
    endsequence
    sequence s_down_wrap;
        st_ff.cnt[2] == 16'h0000 && tick[2] && dn[2] && !cnt_wr[2]
            && !clr_hit[2] && !standby;
    endsequence

    a_ocr_reserved_ones: assert property ( // R1
        (st_ff.ocr & 8'hEC) == 8'hEC)
        else $error("output control reserved bits not one");
    a_standby_init_all: assert property ( // R2
        standby |=> st_ff.ocr == 8'hFF && st_ff.cnt[3] == 16'h0000
            && st_ff.general_reg_b[4] == 16'hFFFF)
        else $error("standby did not initialise registers");
    a_trigger_clears_enable: assert property ( // R5
        cap_a[1] && pair_on && !st_ff.ocr[4] && !standby
            |=> st_ff.oer[5:0] == 6'h00)
        else $error("trigger did not clear master enable");
    a_no_trigger_disabled: assert property ( // R6
        st_ff.ocr[4] && !oer_wr && !standby
            |=> st_ff.oer == $past(st_ff.oer))
        else $error("master enable changed with trigger off");
    a_level_hi_invert: assert property ( // R7
        1'b1 |=> st_ff.pin_lvl[0] == ($past(raw_lvl[0]) ^
            ($past(pair_on) & ~$past(st_ff.ocr[1]))))
        else $error("ch3 A level wrong");
    a_level_lo_invert: assert property ( // R8
        1'b1 |=> st_ff.pin_lvl[4] == ($past(raw_lvl[4]) ^
            ($past(pair_on) & ~$past(st_ff.ocr[0]))))
        else $error("aux A level wrong");
    a_ch0_up_step: assert property ( // R9
        tick[0] && !cnt_wr[0] && !clr_hit[0] && !standby
            |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + 16'h0001)
        else $error("channel 0 did not step up");
    a_clear_on_hit: assert property ( // R13
        clr_hit[1] && !cnt_wr[1] && !standby |=> st_ff.cnt[1] == 16'h0000)
        else $error("counter not cleared on match");
    a_wrap_up_flag: assert property ( // R14
        s_up_wrap |=> st_ff.cnt[0] == 16'h0000 && st_ff.f_wrap[0])
        else $error("up wrap flag missing");
    a_wrap_down_flag: assert property ( // R15
        s_down_wrap |=> st_ff.cnt[2] == 16'hFFFF && st_ff.f_wrap[2])
        else $error("down wrap flag missing");
    a_compare_sets_flag: assert property ( // R19
        (hit_a | hit_b) != 5'h00
            |=> (st_ff.f_a & $past(hit_a)) == $past(hit_a)
            && (st_ff.f_b & $past(hit_b)) == $past(hit_b))
        else $error("match flag not set");
    a_capture_latch_count: assert property ( // R20
        cap_a[0] && !standby
            |=> st_ff.general_reg_a[0] == $past(st_ff.cnt[0]) && st_ff.f_a[0])
        else $error("capture did not latch count");
    a_write_beats_tick: assert property ( // R25
        cnt_wr[4] && cpu.be == 2'b11 && !standby
            |=> st_ff.cnt[4] == $past(cpu.wdata))
        else $error("count write lost to tick");
endmodule : tcc_core

// >>> verif/tcc_pin_model.sv
/*
 far-side model: the capture input pins and the six timer output pins.
 assumes the core drives pin levels and enables on clk; capture is async.
*/
`timescale 1ns/10ps
module tcc_pin_model (
    input wire logic clk,
    input wire logic [9:0] cap_set,
    input wire logic [5:0] pin_lvl,
    input wire logic [5:0] pin_oe_n,
    output logic [9:0] cap_pin,
    output logic [5:0] pin_wire
);
    // ==========================================================
    // capture inputs
    // edge off clock
    // skew keeps pin edges away from the core's sampling edge
    assign #7 cap_pin = cap_set;
    // ==========================================================
    // output pins
    // released pin shows inverted level
    // no pull on these pins, so a released line shows the inverse level
    assign pin_wire = pin_lvl ^ pin_oe_n;
endmodule : tcc_pin_model

// >>> verif/timer_channel_count_compare_tb.sv
/*
 self-checking bench for the five-channel count/compare core.
 assumes the pin model drives capture inputs and shows the pin wires.
*/
`timescale 1ns/10ps
module timer_channel_count_compare_tb;
    // ==========================================================
    // signals
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic standby = 1'b0;
    tcc_pkg::tcc_cpu_req_t cpu = '0;
    tcc_pkg::tcc_chan_cfg_t [4:0] cfg = '0;
    tcc_pkg::tcc_pair_t pair_mode = tcc_pkg::PAIR_NONE;
    logic phase_mode = 1'b0;
    logic [7:0] src_tick = '0;
    logic [9:0] cap_set = '0;
    logic [4:0] clr_p = '0;
    logic [5:0] raw_lvl = 6'h2A;
    logic [5:0] raw_en = 6'h3F;
    logic [15:0] rdata;
    logic [9:0] cap_pin;
    logic [4:0] fw, fa, fb;
    logic [7:0] oer;
    logic [5:0] pin_lvl, pin_oe_n, pin_wire;
    int n_mismatch = 0;
    int n_compared = 0;
    always #10 clk = ~clk;
    tcc_core i_dut (
        .clk(clk), .sys_rst(sys_rst), .standby(standby), .cpu(cpu),
        .cpu_rdata(rdata), .chan_cfg(cfg), .phase_mode(phase_mode),
        .pair_mode(pair_mode), .src_tick(src_tick), .cap_pin(cap_pin),
        .wrap_clr(clr_p), .flag_a_clr(clr_p), .flag_b_clr(clr_p),
        .raw_lvl(raw_lvl), .raw_en(raw_en), .count_wrap_flag(fw),
        .match_capture_flag_a(fa), .match_capture_flag_b(fb),
        .output_master_enable(oer), .pin_lvl(pin_lvl),
        .pin_oe_n(pin_oe_n)
    );
    tcc_pin_model i_pins (
        .clk(clk), .cap_set(cap_set), .pin_lvl(pin_lvl),
        .pin_oe_n(pin_oe_n), .cap_pin(cap_pin), .pin_wire(pin_wire)
    );
    // ==========================================================
    // shared tasks
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [1:0] b,
                      input logic [15:0] d);
        @(posedge clk);
        cpu <= '{1'b1, 1'b0, a, b, d};
        @(posedge clk);
        cpu <= '0;
    endtask : wr
    task automatic chk_reg(input string what, input logic [4:0] a,
                           input logic [15:0] exp);
        @(posedge clk);
        cpu <= '{1'b0, 1'b1, a, 2'h3, 16'h0000};
        @(posedge clk);
        cpu <= '0;
        #1;
        chk(what, exp, rdata);
    endtask : chk_reg
    task automatic pulse(input logic [7:0] t, input logic [4:0] c);
        @(posedge clk);
        src_tick <= t;
        clr_p <= c;
        @(posedge clk);
        src_tick <= 8'h00;
        clr_p <= 5'h00;
        #1;
    endtask : pulse
    // capture answers within about 3 cycles; 6 leaves margin
    task automatic cap(input int i, input logic v);
        @(posedge clk);
        cap_set[i] <= v;
        repeat (6) @(posedge clk);
        #1;
    endtask : cap
    // ==========================================================
    // scenarios
    task automatic t_reset;
        chk_reg("cnt0", 5'h00, 16'h0000);
        chk_reg("grb2", 5'h08, 16'hFFFF);
        chk_reg("ocr", 5'h0F, 16'h00FF);
        chk_reg("unmapped", 5'h1F, 16'h0000);
        wr(5'h0F, 2'h1, 16'h0000);
        chk_reg("ocr rsv", 5'h0F, 16'h00EC);
        wr(5'h09, 2'h3, 16'h0123);
        wr(5'h0A, 2'h3, 16'h0456);
        @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        chk_reg("cnt3 sb", 5'h09, 16'h0000);
        chk_reg("gra3 sb", 5'h0A, 16'hFFFF);
        chk_reg("ocr sb", 5'h0F, 16'h00FF);
    endtask : t_reset
    task automatic t_bytes;
        wr(5'h0C, 2'h3, 16'h1234);
        wr(5'h0C, 2'h2, 16'hABCD);
        wr(5'h0C, 2'h1, 16'h00EF);
        chk_reg("cnt4 bytes", 5'h0C, 16'hABEF);
        @(posedge clk);
        cpu <= '{1'b1, 1'b0, 5'h0C, 2'h3, 16'h0100};
        src_tick <= 8'h01;
        @(posedge clk);
        cpu <= '0;
        src_tick <= 8'h00;
        chk_reg("cnt4 wr tick", 5'h0C, 16'h0100);
    endtask : t_bytes
    task automatic t_wrap;
        wr(5'h00, 2'h3, 16'hFFFF);
        @(posedge clk);
        cfg[0].down <= 1'b1;
        pulse(8'h00, 5'h1F);
        pulse(8'h01, 5'h00);
        chk("wrap up", 16'h0001, 16'(fw));
        chk_reg("cnt0 up", 5'h00, 16'h0000);
        wr(5'h06, 2'h3, 16'h0000);
        wr(5'h09, 2'h3, 16'h0000);
        @(posedge clk);
        phase_mode <= 1'b1;
        cfg[2].down <= 1'b1;
        cfg[3].down <= 1'b1;
        pulse(8'h00, 5'h1F);
        pulse(8'h01, 5'h00);
        chk("wrap down", 16'h0004, 16'(fw));
        chk_reg("cnt2 down", 5'h06, 16'hFFFF);
        chk_reg("cnt3 up", 5'h09, 16'h0001);
        @(posedge clk);
        phase_mode <= 1'b0;
        cfg <= '0;
    endtask : t_wrap
    task automatic t_compare;
        @(posedge clk);
        cfg[1].prescale_select <= 3'h5;
        cfg[1].clr <= tcc_pkg::CLR_A;
        wr(5'h04, 2'h3, 16'h0005);
        wr(5'h05, 2'h3, 16'h0004);
        wr(5'h03, 2'h3, 16'h0004);
        pulse(8'h01, 5'h1F);
        chk("match b1", 16'h0001, 16'(fb[1]));
        chk_reg("cnt1 other tick", 5'h03, 16'h0004);
        pulse(8'h20, 5'h00);
        @(posedge clk);
        #1;
        chk("match a1", 16'h0001, 16'(fa[1]));
        chk_reg("cnt1 cleared", 5'h03, 16'h0000);
    endtask : t_compare
    task automatic t_capture;
        @(posedge clk);
        cfg[0].io_a <= tcc_pkg::IO_RISE;
        wr(5'h00, 2'h3, 16'h0042);
        pulse(8'h00, 5'h1F);
        cap(0, 1'b1);
        chk("capture a0", 16'h0001, 16'(fa[0]));
        chk_reg("gra0 cap", 5'h01, 16'h0042);
        @(posedge clk);
        cfg[0].pwm <= 1'b1;
        wr(5'h00, 2'h3, 16'h0077);
        cap(0, 1'b0);
        cap(0, 1'b1);
        chk_reg("gra0 pwm", 5'h01, 16'h0042);
        @(posedge clk);
        cfg[0] <= '0;
    endtask : t_capture
    task automatic t_trigger;
        tcc_pkg::tcc_pair_t pm[3];
        logic [7:0] oc[3];
        logic [7:0] ex[3];
        pm = '{tcc_pkg::PAIR_COMP, tcc_pkg::PAIR_NONE, tcc_pkg::PAIR_RSYNC};
        oc = '{8'hFF, 8'hEF, 8'hEF};
        ex = '{8'hFF, 8'hFF, 8'hC0};
        @(posedge clk);
        cfg[1].io_a <= tcc_pkg::IO_RISE;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            pair_mode <= pm[k];
            wr(5'h0F, 2'h1, 16'(oc[k]));
            cap(2, 1'b1);
            cap(2, 1'b0);
            chk_reg("oer trig", 5'h10, 16'(ex[k]));
            chk("oer out", 16'(ex[k]), 16'(oer));
        end
        wr(5'h10, 2'h1, 16'h00FF);
        @(posedge clk);
        cfg[1] <= '0;
    endtask : t_trigger
    task automatic t_pins;
        tcc_pkg::tcc_pair_t pm[3];
        logic [7:0] oc[3];
        logic [5:0] ex[3];
        pm = '{tcc_pkg::PAIR_COMP, tcc_pkg::PAIR_COMP, tcc_pkg::PAIR_NONE};
        oc = '{8'hFD, 8'hFE, 8'hFC};
        ex = '{6'h27, 6'h18, 6'h2A};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            pair_mode <= pm[k];
            wr(5'h0F, 2'h1, 16'(oc[k]));
            repeat (2) @(posedge clk);
            #1;
            chk("pin_lvl", 16'(ex[k]), 16'(pin_lvl));
            chk("pin_wire", 16'(ex[k]), 16'(pin_wire));
        end
        wr(5'h10, 2'h1, 16'h00FE);
        repeat (2) @(posedge clk);
        #1;
        chk("pin_oe_n", 16'h0001, 16'(pin_oe_n));
        chk("pin_wire off", 16'h002B, 16'(pin_wire));
    endtask : t_pins
    // ==========================================================
    // run control
    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_bytes;
        t_wrap;
        t_compare;
        t_capture;
        t_trigger;
        t_pins;
        stop_test;
    end
    // whole run takes well under 600 cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        stop_test;
    end
endmodule : timer_channel_count_compare_tb
